// ===== core/sfp_pkg.sv
package sfp_pkg;

    // Byte addresses of the 24-bit output D divider configuration register
    localparam logic [7:0]  SFP_ADDR_CFG_HI   = 8'h89;
    localparam logic [7:0]  SFP_ADDR_CFG_MID  = 8'h8A;
    localparam logic [7:0]  SFP_ADDR_CFG_LO   = 8'h8B;
    localparam logic [23:0] SFP_CFG_RESET     = 24'h000040;

    // Field positions
    localparam int          SFP_MODE_MSB      = 23;
    localparam int          SFP_MODE_LSB      = 20;
    localparam int          SFP_TYPE_BIT      = 19;
    localparam int          SFP_POL_BIT       = 18;
    localparam int          SFP_SRC_MSB       = 17;
    localparam int          SFP_SRC_LSB       = 16;
    localparam int          SFP_RATE_MSB      = 15;
    localparam int          SFP_CFG_W         = 24;
    localparam int          SFP_RATE_W        = 16;
    localparam logic [3:0]  SFP_MODE_SPECIAL  = 4'hF;

    // Synchroniser lanes
    localparam int          SFP_LANE_BASE     = 3;
    localparam int          SFP_LANES         = 4;

    typedef enum logic [1:0] {
        SFP_SRC_A  = 2'b00,
        SFP_SRC_B  = 2'b01,
        SFP_SRC_C  = 2'b10,
        SFP_SRC_LF = 2'b11
    } sfp_src_t;

    typedef enum logic [1:0] {
        SFP_OUT_DIV   = 2'b00,
        SFP_OUT_LF    = 2'b01,
        SFP_OUT_FRAME = 2'b10
    } sfp_mode_t;

    typedef struct packed {
        logic [SFP_CFG_W-1:0]  cfg;
        logic [SFP_LANES-1:0]  s1;
        logic [SFP_LANES-1:0]  s2;
        logic [SFP_LANES-1:0]  s3;
        logic [SFP_RATE_W-1:0] fcnt;
        logic                  pulse;
        logic                  out;
        logic [7:0]            rd;
    } sfp_state_t;

    localparam sfp_state_t SFP_STATE_RESET = '{cfg: SFP_CFG_RESET, default: '0};

endpackage

// ===== core/sfp_half_div.sv
`timescale 1ns/1ps
`default_nettype none
module sfp_half_div
    import sfp_pkg::*;
#(
    parameter int W = 24
) (
    input  wire logic         clk_in,
    input  wire logic         nrst_in,
    input  wire logic         restart_in,
    input  wire logic         tick_in,
    input  wire logic [W-1:0] div_in,
    output var  logic         div_out
);

    generate
        if (W < 2) begin : g_bad_w
            $error("sfp_half_div: W must be at least 2");
        end
    endgenerate

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         out;
    } sfp_div_state_t;

    sfp_div_state_t q;
    sfp_div_state_t d;
    logic [W-1:0]   div_eff;
    logic [W:0]     half;
    logic [W-1:0]   cnt_nx;

    always_comb begin
        d       = q;
        // Divide by 0 or 1 runs as divide by 2
        div_eff = (div_in < W'(2)) ? W'(2) : div_in;
        // High phase is the larger half, so odd ratios skew by one tick only
        half    = ({1'b0, div_eff} + (W+1)'(1)) >> 1;
        cnt_nx  = (q.cnt >= div_eff - W'(1)) ? '0 : q.cnt + W'(1);
        if (restart_in) begin
            d.cnt = '0;
            d.out = 1'b1;
        end else if (tick_in) begin
            d.cnt = cnt_nx;
            d.out = ({1'b0, cnt_nx} < half);
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            q <= '{cnt: '0, out: 1'b1};
        end else begin
            q <= d;
        end
    end

    assign div_out = q.out;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    a_cnt_in_range: assert property (
        restart_in || ({1'b0, q.cnt} < {1'b0, div_eff}) || $changed(div_in))
        else $error("Divider count beyond ratio");

    a_duty_even_phase: assert property (
        !restart_in && tick_in && !div_eff[0] && q.cnt == div_eff - W'(1)
        && $stable(div_in) |=> div_out)
        else $error("Even ratio did not return high at wrap");

    a_restart_high: assert property (
        restart_in |=> (q.cnt == '0) && div_out)
        else $error("Restart did not clear divider");

endmodule
`default_nettype wire

// ===== core/sfp_frame_gen.sv
`timescale 1ns/1ps
`default_nettype none
module sfp_frame_gen
    import sfp_pkg::*;
(
    input  wire logic       CLK_IN,
    input  wire logic       NRST_IN,
    input  wire logic       WR_EN_IN,
    input  wire logic [7:0] ADDR_IN,
    input  wire logic [7:0] WR_DATA_IN,
    output var  logic [7:0] RD_DATA_OUT,
    input  wire logic       POSTDIV_A_IN,
    input  wire logic       POSTDIV_B_IN,
    input  wire logic       POSTDIV_C_IN,
    input  wire logic       BASE_CLK_IN,
    output var  logic       POSTDIV_D_OUT
);

    sfp_state_t             q;
    sfp_state_t             d;
    sfp_mode_t              mode;
    sfp_src_t               src;
    logic [SFP_RATE_W-1:0]  rate;
    logic [SFP_RATE_W-1:0]  rate_last;
    logic [SFP_LANES-1:0]   rise;
    logic [SFP_LANES-1:0]   fall;
    logic                   sel_rise;
    logic                   sel_fall;
    logic                   boundary;
    logic                   restart;
    logic                   pol;
    logic                   edge_type;
    logic                   div_tick;
    logic [SFP_CFG_W-1:0]   div_val;
    logic                   div_clk;

    always_comb begin
        rate      = q.cfg[SFP_RATE_MSB:0];
        src       = sfp_src_t'(q.cfg[SFP_SRC_MSB:SFP_SRC_LSB]);
        pol       = q.cfg[SFP_POL_BIT];
        edge_type = q.cfg[SFP_TYPE_BIT];
        if (q.cfg[SFP_MODE_MSB:SFP_MODE_LSB] != SFP_MODE_SPECIAL) begin
            mode = SFP_OUT_DIV;
        end else if (src == SFP_SRC_LF) begin
            mode = SFP_OUT_LF;
        end else begin
            mode = SFP_OUT_FRAME;
        end
        rate_last = (rate == '0) ? '0 : rate - SFP_RATE_W'(1);
        rise      = q.s2 & ~q.s3;
        fall      = ~q.s2 & q.s3;
        unique case (src)
            SFP_SRC_A: begin
                sel_rise = rise[0];
                sel_fall = fall[0];
            end
            SFP_SRC_B: begin
                sel_rise = rise[1];
                sel_fall = fall[1];
            end
            SFP_SRC_C: begin
                sel_rise = rise[2];
                sel_fall = fall[2];
            end
            SFP_SRC_LF: begin
                sel_rise = 1'b0;
                sel_fall = 1'b0;
            end
        endcase
        boundary = sel_rise && (q.fcnt == rate_last);
        restart  = WR_EN_IN && (ADDR_IN == SFP_ADDR_CFG_HI || ADDR_IN == SFP_ADDR_CFG_MID
                   || ADDR_IN == SFP_ADDR_CFG_LO);
        // Low-frequency mode counts both base edges, i.e. ticks at twice the base rate
        if (mode == SFP_OUT_LF) begin
            div_tick = rise[SFP_LANE_BASE] | fall[SFP_LANE_BASE];
            div_val  = {8'h00, rate};
        end else begin
            div_tick = 1'b1;
            div_val  = q.cfg;
        end
    end

    sfp_half_div #(
        .W          (SFP_CFG_W)
    ) u_div (
        .clk_in     (CLK_IN),
        .nrst_in    (NRST_IN),
        .restart_in (restart),
        .tick_in    (div_tick),
        .div_in     (div_val),
        .div_out    (div_clk)
    );

    always_comb begin
        d    = q;
        d.s1 = {BASE_CLK_IN, POSTDIV_C_IN, POSTDIV_B_IN, POSTDIV_A_IN};
        d.s2 = q.s1;
        d.s3 = q.s2;
        if (mode == SFP_OUT_FRAME) begin
            if (sel_rise) begin
                d.fcnt = boundary ? '0 : q.fcnt + SFP_RATE_W'(1);
            end
            if (edge_type && sel_rise) begin
                d.pulse = boundary;
            end else if (!edge_type && sel_fall) begin
                d.pulse = (q.fcnt == rate_last);
            end
        end else begin
            d.fcnt  = '0;
            d.pulse = 1'b0;
        end
        if (restart) begin
            d.fcnt  = '0;
            d.pulse = 1'b0;
            unique case (ADDR_IN)
                SFP_ADDR_CFG_HI:  d.cfg[23:16] = WR_DATA_IN;
                SFP_ADDR_CFG_MID: d.cfg[15:8]  = WR_DATA_IN;
                default:          d.cfg[7:0]   = WR_DATA_IN;
            endcase
        end
        d.out = (mode == SFP_OUT_FRAME) ? (q.pulse ^ pol) : div_clk;
        unique case (ADDR_IN)
            SFP_ADDR_CFG_HI:  d.rd = q.cfg[23:16];
            SFP_ADDR_CFG_MID: d.rd = q.cfg[15:8];
            SFP_ADDR_CFG_LO:  d.rd = q.cfg[7:0];
            default:          d.rd = 8'h00;
        endcase
    end

    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            q <= SFP_STATE_RESET;
        end else begin
            q <= d;
        end
    end

    assign RD_DATA_OUT   = q.rd;
    assign POSTDIV_D_OUT = q.out;

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!NRST_IN);

    sequence s_frame_wrap;
        (mode == SFP_OUT_FRAME) && !restart && sel_rise && (q.fcnt == rate_last);
    endsequence

    sequence s_lead_start;
        s_frame_wrap ##0 edge_type;
    endsequence

    a_frame_count_wrap: assert property (
        s_frame_wrap |=> q.fcnt == '0)
        else $error("Frame counter did not wrap at rate");

    a_frame_count_step: assert property (
        (mode == SFP_OUT_FRAME) && !restart && sel_rise && (q.fcnt != rate_last)
        |=> q.fcnt == $past(q.fcnt) + SFP_RATE_W'(1))
        else $error("Frame counter did not advance");

    a_lead_pulse_start: assert property (
        s_lead_start ##1 ($stable(q.cfg) && !restart) |=> POSTDIV_D_OUT == !pol)
        else $error("Start-edge pulse not asserted at boundary");

    a_src_decode_sel: assert property (
        (src == SFP_SRC_B) |-> (sel_rise == rise[1]) && (sel_fall == fall[1]))
        else $error("Source B not selected");

    a_polarity_idle: assert property (
        (mode == SFP_OUT_FRAME) && !q.pulse && $stable(q.cfg) |=> POSTDIV_D_OUT == $past(pol))
        else $error("Idle frame level does not follow polarity");

    a_div_mode_out: assert property (
        (mode == SFP_OUT_DIV) |=> POSTDIV_D_OUT == $past(div_clk))
        else $error("Divider output not routed");

    a_lf_tick_base: assert property (
        (mode == SFP_OUT_LF) && !(rise[SFP_LANE_BASE] || fall[SFP_LANE_BASE])
        |-> !div_tick)
        else $error("Low-frequency divider ticked without base edge");

    a_write_restart: assert property (
        restart |=> (q.fcnt == '0) && !q.pulse)
        else $error("Write did not restart frame counter");

    a_pulse_width_one: assert property (
        (mode == SFP_OUT_FRAME) && edge_type && !restart && sel_rise && q.pulse
        && (rate_last != '0) |=> !q.pulse)
        else $error("Frame pulse longer than one source period");

endmodule
`default_nettype wire

// ===== verification/sfp_frame_gen_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sfp_frame_gen_bench
    import sfp_pkg::*;
;
    logic        clk     = 1'b0;
    logic        nrst    = 1'b0;
    logic        wr_en   = 1'b0;
    logic [7:0]  addr    = 8'h00;
    logic [7:0]  wr_data = 8'h00;
    logic [7:0]  rd_data;
    logic [3:0]  src_clk = 4'h0;
    logic        dout;
    logic [1:0]  sel     = 2'b00;
    logic        edge_src;
    int          err_total = 0;
    int          tests_run = 0;
    int          tick      = 0;
    int          n1;
    int          n2;
    logic [23:0] div_tab [4] = '{24'h000002, 24'h000007, 24'h000029, 24'h00012C};

    always #2.5 clk = ~clk;

    // Sibling clocks A, B, C and base clock, half periods 6, 8, 10 and 10 cycles
    always @(negedge clk) begin
        tick       <= tick + 1;
        src_clk[0] <= 1'((tick / 6) % 2);
        src_clk[1] <= 1'((tick / 8) % 2);
        src_clk[2] <= 1'((tick / 10) % 2);
        src_clk[3] <= 1'((tick / 10) % 2);
    end

    sfp_frame_gen DUT (
        .CLK_IN        (clk),
        .NRST_IN       (nrst),
        .WR_EN_IN      (wr_en),
        .ADDR_IN       (addr),
        .WR_DATA_IN    (wr_data),
        .RD_DATA_OUT   (rd_data),
        .POSTDIV_A_IN  (src_clk[0]),
        .POSTDIV_B_IN  (src_clk[1]),
        .POSTDIV_C_IN  (src_clk[2]),
        .BASE_CLK_IN   (src_clk[3]),
        .POSTDIV_D_OUT (dout)
    );

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        wr_en   = 1'b1;
        addr    = a;
        wr_data = d;
    endtask

    task automatic idle();
        @(negedge clk);
        wr_en = 1'b0;
    endtask

    task automatic set_cfg(input logic [23:0] v);
        wr(SFP_ADDR_CFG_HI, v[23:16]);
        wr(SFP_ADDR_CFG_MID, v[15:8]);
        wr(SFP_ADDR_CFG_LO, v[7:0]);
        idle();
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        addr = a;
        @(negedge clk);
        check("read byte", {24'h0, exp}, {24'h0, rd_data});
    endtask

    // Counts cycles while the output stays at one level, bounded
    task automatic span(input logic lvl, output int n);
        n = 0;
        while (dout === lvl && n < 2000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 2000) begin
            err_total++;
            $display("wrong value %s expected %0d seen %0d", "level span", 2000, n);
            wrap_up();
        end
    endtask

    task automatic measure(input string name, input logic lvl, input int act, input int rest);
        span(lvl, n1);
        span(~lvl, n1);
        edge_src = src_clk[sel];
        span(lvl, n1);
        span(~lvl, n2);
        check(name, act, n1);
        check(name, rest, n2);
    endtask

    initial begin
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        rd(SFP_ADDR_CFG_HI, 8'h00);
        rd(SFP_ADDR_CFG_MID, 8'h00);
        rd(SFP_ADDR_CFG_LO, 8'h40);
        rd(8'h8C, 8'h00);
        wr(8'h8C, 8'hFF);
        idle();
        rd(SFP_ADDR_CFG_LO, 8'h40);
        $display("test registers done");
        measure("default ratio", 1'b1, 32, 32);
        span(1'b1, n1);
        repeat (3) @(negedge clk);
        wr(SFP_ADDR_CFG_LO, 8'h40);
        idle();
        repeat (2) @(negedge clk);
        check("restart level", 1, dout);
        $display("test restart done");
        foreach (div_tab[i]) begin
            set_cfg(div_tab[i]);
            measure("divider", 1'b1, (int'(div_tab[i]) + 1) / 2, int'(div_tab[i]) / 2);
        end
        $display("test divider done");
        set_cfg(24'hF30004);
        rd(SFP_ADDR_CFG_HI, 8'hF3);
        measure("low freq", 1'b1, 20, 20);
        set_cfg(24'hF30006);
        measure("low freq", 1'b1, 30, 30);
        $display("test low frequency done");
        for (int s = 0; s < 3; s++) begin
            for (int t = 0; t < 2; t++) begin
                for (int p = 0; p < 2; p++) begin
                    sel = 2'(s);
                    set_cfg({4'hF, 1'(t), 1'(p), 2'(s), 16'h0003});
                    measure("frame", ~1'(p), 12 + 4 * s, 3 * (12 + 4 * s) - (12 + 4 * s));
                    check("frame phase", t, edge_src);
                end
            end
        end
        $display("test frame done");
        wrap_up();
    end
endmodule
`default_nettype wire
